// >>> design/rtcdt_defs.vh
// Constants for the dual countdown timer block
`ifndef RTCDT_DEFS_VH
`define RTCDT_DEFS_VH

// Register offsets
`define RTCDT_ADDR_FIRST_CLOCK_SELECT  5'h10
`define RTCDT_ADDR_FIRST_COUNT_VALUE   5'h11
`define RTCDT_ADDR_SECOND_CLOCK_WIDTH  5'h12
`define RTCDT_ADDR_SECOND_COUNT_VALUE  5'h13

// Reset values
`define RTCDT_RST_FIRST_CLOCK_SELECT   8'h07
`define RTCDT_RST_SECOND_CLOCK_WIDTH   8'h07
`define RTCDT_RST_COUNT_VALUE          8'h00

// Field positions
`define RTCDT_TICK_SEL_MSB  2
`define RTCDT_TICK_SEL_LSB  0
`define RTCDT_WIDTH_SEL_MSB 6
`define RTCDT_WIDTH_SEL_LSB 4

// Tick source codes
`define RTCDT_TICK_4096HZ   3'h0
`define RTCDT_TICK_64HZ     3'h1
`define RTCDT_TICK_1HZ      3'h2
`define RTCDT_TICK_MINUTE   3'h3
`define RTCDT_TICK_HOUR     3'h7

// First timer function codes
`define RTCDT_FUNC_OFF       2'h0
`define RTCDT_FUNC_COUNTDOWN 2'h1
`define RTCDT_FUNC_WATCHDOG  2'h2

// Prescaler taps, counted in 32.768 kHz oscillator ticks
`define RTCDT_OSC_PER_4096HZ 15'h0007
`define RTCDT_OSC_PER_64HZ   15'h01ff
`define RTCDT_OSC_PER_1HZ    15'h7fff
`define RTCDT_LAST_UNIT      6'h3b

// Interrupt pulse widths in oscillator ticks (one tick is 30.517578 us)
`define RTCDT_PW_122US       13'h0004
`define RTCDT_PW_244US       13'h0008
`define RTCDT_PW_7812US      13'h0100
`define RTCDT_PW_15625US     13'h0200
`define RTCDT_PW_46875US     13'h0600
`define RTCDT_PW_62500US     13'h0800
`define RTCDT_PW_78125US     13'h0a00
`define RTCDT_PW_93750US     13'h0c00
`define RTCDT_PW_125000US    13'h1000
`define RTCDT_PW_156250US    13'h1400
`define RTCDT_PW_187500US    13'h1800
`define RTCDT_PW_218750US    13'h1c00

`endif

// >>> design/rtcdt_prescale.v
// Oscillator divider producing the five timer source ticks
`timescale 1ns/1ps
`include "rtcdt_defs.vh"

module rtcdt_prescale (
   input wire i_clk,
   input wire i_rst,
   input wire i_osc_en,
   output reg o_tick_4096,
   output reg o_tick_64,
   output reg o_tick_1,
   output reg o_tick_minute,
   output reg o_tick_hour
);

reg [14:0] div;
reg [5:0] sec;
reg [5:0] min;
wire sec_end = i_osc_en && (div == `RTCDT_OSC_PER_1HZ);
wire min_end = sec_end && (sec == `RTCDT_LAST_UNIT);
wire hour_end = min_end && (min == `RTCDT_LAST_UNIT);

always @(posedge i_clk) begin
   if (i_rst) begin
      div <= 15'h0000;
      sec <= 6'h00;
      min <= 6'h00;
      o_tick_4096 <= 1'b0;
      o_tick_64 <= 1'b0;
      o_tick_1 <= 1'b0;
      o_tick_minute <= 1'b0;
      o_tick_hour <= 1'b0;
   end else begin
      if (i_osc_en) begin
         div <= div + 15'h0001;
      end
      if (sec_end) begin
         sec <= (sec == `RTCDT_LAST_UNIT) ? 6'h00 : sec + 6'h01;
      end
      if (min_end) begin
         min <= (min == `RTCDT_LAST_UNIT) ? 6'h00 : min + 6'h01;
      end
      o_tick_4096 <= i_osc_en && ((div & `RTCDT_OSC_PER_4096HZ) == `RTCDT_OSC_PER_4096HZ);
      o_tick_64 <= i_osc_en && ((div & `RTCDT_OSC_PER_64HZ) == `RTCDT_OSC_PER_64HZ);
      o_tick_1 <= sec_end;
      o_tick_minute <= min_end;
      o_tick_hour <= hour_end;
   end
end

endmodule

// >>> design/rtcdt_timers.v
// Two 8-bit down-counting timers with watchdog, flags and interrupt pins
//
// Overview of operation
// - First tick select picks one of five sources
// - Second tick select in bits 2..0, same codes
// - Bits 6..4 pick second pulse width
// - Each timer holds an 8-bit count n
// - Function 01 countdown, 10 watchdog
// - Watchdog sets expired flag after count 1
// - Watchdog interrupt only when its enable set
// - Nonzero watchdog write clears flag and restarts
// - Zero watchdog write clears flag and stops
// - Control two read clears watchdog flag
// - Pulse mode bit shapes watchdog interrupt
// - Countdown expiry sets flag and reloads n
// - First countdown flag cleared only by host
// - Value reads return the live count
// - Mid-period writes take effect at once
// - Count zero halts timer, no more expiries
// - First period offset depends on tick source
// - First countdown flag drives primary interrupt
// - Second timer is countdown only, one enable
// - Second expiry sets flag, reloads, both interrupts
// - Second countdown flag cleared only by host
// - Bit 7 selects first timer pulse style
// - Bit 6 selects second timer pulse style
`timescale 1ns/1ps
`include "rtcdt_defs.vh"

module rtcdt_timers (
   input wire i_clk,
   input wire i_rst,
   input wire i_osc_en,
   input wire [4:0] i_reg_addr,
   input wire [7:0] i_reg_wdata,
   input wire i_reg_we,
   input wire i_reg_re,
   output reg [7:0] o_reg_rdata,
   input wire [1:0] i_first_function_select,
   input wire i_second_timer_on,
   input wire i_first_pulse_mode,
   input wire i_second_pulse_mode,
   input wire i_watchdog_irq_enable,
   input wire i_first_countdown_irq_enable,
   input wire i_second_countdown_irq_enable,
   input wire i_control2_read,
   input wire i_first_countdown_flag_clear,
   input wire i_second_countdown_flag_clear,
   output reg o_watchdog_expired_flag,
   output reg o_first_countdown_flag,
   output reg o_second_countdown_flag,
   output reg o_irq_out_primary_n,
   output reg o_irq_out_secondary_n
);

wire tick_4096;
wire tick_64;
wire tick_1;
wire tick_minute;
wire tick_hour;

rtcdt_prescale u_prescale (
   .i_clk(i_clk),
   .i_rst(i_rst),
   .i_osc_en(i_osc_en),
   .o_tick_4096(tick_4096),
   .o_tick_64(tick_64),
   .o_tick_1(tick_1),
   .o_tick_minute(tick_minute),
   .o_tick_hour(tick_hour)
);

// Unlisted codes give no tick, so such a timer simply never counts
function tick_pick;
   input [2:0] sel;
   input t4096;
   input t64;
   input t1;
   input tmin;
   input thour;
   begin
      case (sel)
         `RTCDT_TICK_4096HZ: tick_pick = t4096;
         `RTCDT_TICK_64HZ: tick_pick = t64;
         `RTCDT_TICK_1HZ: tick_pick = t1;
         `RTCDT_TICK_MINUTE: tick_pick = tmin;
         `RTCDT_TICK_HOUR: tick_pick = thour;
         default: tick_pick = 1'b0;
      endcase
   end
endfunction

// Slow sources align to a 64 Hz tick before their first count
function is_slow;
   input [2:0] sel;
   begin
      is_slow = (sel != `RTCDT_TICK_4096HZ) && (sel != `RTCDT_TICK_64HZ);
   end
endfunction

function [12:0] width_code;
   input [2:0] code;
   begin
      case (code)
         3'h0: width_code = `RTCDT_PW_46875US;
         3'h1: width_code = `RTCDT_PW_62500US;
         3'h2: width_code = `RTCDT_PW_78125US;
         3'h3: width_code = `RTCDT_PW_93750US;
         3'h4: width_code = `RTCDT_PW_125000US;
         3'h5: width_code = `RTCDT_PW_156250US;
         3'h6: width_code = `RTCDT_PW_187500US;
         default: width_code = `RTCDT_PW_218750US;
      endcase
   end
endfunction

// Pulse length after an expiry; programmable width only on the second timer
function [12:0] pulse_len;
   input [2:0] sel;
   input [7:0] n;
   input second;
   input [2:0] wcode;
   reg [16:0] period;
   begin
      period = {n, 9'h000};
      if (sel == `RTCDT_TICK_4096HZ) begin
         pulse_len = (n == 8'h01) ? `RTCDT_PW_122US : `RTCDT_PW_244US;
      end else if (sel == `RTCDT_TICK_64HZ && n == 8'h01) begin
         pulse_len = `RTCDT_PW_7812US;
      end else if (!second) begin
         pulse_len = `RTCDT_PW_15625US;
      end else if (sel == `RTCDT_TICK_64HZ && period < {4'h0, width_code(wcode)}) begin
         pulse_len = `RTCDT_PW_15625US;
      end else begin
         pulse_len = width_code(wcode);
      end
   end
endfunction

reg [7:0] first_clock_select;
reg [7:0] first_n;
reg [7:0] first_cnt;
reg first_wait;
reg [1:0] first_mode_q;
reg [12:0] first_pulse;
reg [7:0] second_clock_width;
reg [7:0] second_n;
reg [7:0] second_cnt;
reg second_wait;
reg second_on_q;
reg [12:0] second_pulse;

wire [2:0] first_tick_select = first_clock_select[`RTCDT_TICK_SEL_MSB:`RTCDT_TICK_SEL_LSB];
wire [2:0] second_tick_select = second_clock_width[`RTCDT_TICK_SEL_MSB:`RTCDT_TICK_SEL_LSB];
wire [2:0] second_pulse_width = second_clock_width[`RTCDT_WIDTH_SEL_MSB:`RTCDT_WIDTH_SEL_LSB];

wire first_is_cd = (i_first_function_select == `RTCDT_FUNC_COUNTDOWN);
wire first_is_wd = (i_first_function_select == `RTCDT_FUNC_WATCHDOG);
wire first_active = first_is_cd || first_is_wd;
wire first_was_active = (first_mode_q == `RTCDT_FUNC_COUNTDOWN) ||
   (first_mode_q == `RTCDT_FUNC_WATCHDOG);
wire first_write = i_reg_we && (i_reg_addr == `RTCDT_ADDR_FIRST_COUNT_VALUE);
wire first_start = first_active && !first_was_active;
wire first_tick = tick_pick(first_tick_select, tick_4096, tick_64, tick_1,
   tick_minute, tick_hour);
wire first_run = first_active && (first_cnt != 8'h00);
wire first_expire = !first_write && !first_start && first_run && !first_wait &&
   first_tick && (first_cnt == 8'h01);
// Fast sources skip one own tick first, so the first period is n to n+1 ticks
wire first_align = is_slow(first_tick_select) ? tick_64 : first_tick;

wire second_write = i_reg_we && (i_reg_addr == `RTCDT_ADDR_SECOND_COUNT_VALUE);
wire second_start = i_second_timer_on && !second_on_q;
wire second_tick = tick_pick(second_tick_select, tick_4096, tick_64, tick_1,
   tick_minute, tick_hour);
wire second_run = i_second_timer_on && (second_cnt != 8'h00);
wire second_expire = !second_write && !second_start && second_run && !second_wait &&
   second_tick && (second_cnt == 8'h01);
wire second_align = is_slow(second_tick_select) ? tick_64 : second_tick;

// Register file; every load is one whole-byte update in this clock, never torn
always @(posedge i_clk) begin
   if (i_rst) begin
      first_clock_select <= `RTCDT_RST_FIRST_CLOCK_SELECT;
      second_clock_width <= `RTCDT_RST_SECOND_CLOCK_WIDTH;
      first_n <= `RTCDT_RST_COUNT_VALUE;
      second_n <= `RTCDT_RST_COUNT_VALUE;
   end else if (i_reg_we) begin
      case (i_reg_addr)
         `RTCDT_ADDR_FIRST_CLOCK_SELECT: first_clock_select <= {5'h00, i_reg_wdata[2:0]};
         `RTCDT_ADDR_FIRST_COUNT_VALUE: first_n <= i_reg_wdata;
         `RTCDT_ADDR_SECOND_CLOCK_WIDTH:
            second_clock_width <= {1'b0, i_reg_wdata[6:4], 1'b0, i_reg_wdata[2:0]};
         `RTCDT_ADDR_SECOND_COUNT_VALUE: second_n <= i_reg_wdata;
         // Unmapped offsets keep everything
         default: first_n <= first_n;
      endcase
   end
end

// Read data; unused bits and unmapped offsets read zero
always @(posedge i_clk) begin
   if (i_rst) begin
      o_reg_rdata <= 8'h00;
   end else if (i_reg_re) begin
      case (i_reg_addr)
         `RTCDT_ADDR_FIRST_CLOCK_SELECT: o_reg_rdata <= first_clock_select;
         `RTCDT_ADDR_FIRST_COUNT_VALUE: o_reg_rdata <= first_cnt;
         `RTCDT_ADDR_SECOND_CLOCK_WIDTH: o_reg_rdata <= second_clock_width;
         `RTCDT_ADDR_SECOND_COUNT_VALUE: o_reg_rdata <= second_cnt;
         default: o_reg_rdata <= 8'h00;
      endcase
   end
end

// First timer counter
always @(posedge i_clk) begin
   if (i_rst) begin
      first_cnt <= 8'h00;
      first_wait <= 1'b0;
      first_mode_q <= `RTCDT_FUNC_OFF;
   end else begin
      first_mode_q <= i_first_function_select;
      if (first_write) begin
         first_cnt <= i_reg_wdata;
         first_wait <= 1'b1;
      end else if (first_start) begin
         first_cnt <= first_n;
         first_wait <= 1'b1;
      end else if (first_run) begin
         if (first_wait) begin
            if (first_align) begin
               first_wait <= 1'b0;
            end
         end else if (first_tick) begin
            // Watchdog parks at zero after expiry until rewritten
            if (first_cnt == 8'h01) begin
               first_cnt <= first_is_cd ? first_n : 8'h00;
            end else begin
               first_cnt <= first_cnt - 8'h01;
            end
         end
      end
   end
end

// Second timer counter
always @(posedge i_clk) begin
   if (i_rst) begin
      second_cnt <= 8'h00;
      second_wait <= 1'b0;
      second_on_q <= 1'b0;
   end else begin
      second_on_q <= i_second_timer_on;
      if (second_write) begin
         second_cnt <= i_reg_wdata;
         second_wait <= 1'b1;
      end else if (second_start) begin
         second_cnt <= second_n;
         second_wait <= 1'b1;
      end else if (second_run) begin
         if (second_wait) begin
            if (second_align) begin
               second_wait <= 1'b0;
            end
         end else if (second_tick) begin
            if (second_cnt == 8'h01) begin
               second_cnt <= second_n;
            end else begin
               second_cnt <= second_cnt - 8'h01;
            end
         end
      end
   end
end

// Flags: a set in the cycle of a clear wins
// Watchdog write clear acts only in watchdog mode
wire wd_set = first_expire && first_is_wd;
wire wd_clr = i_control2_read || (first_write && first_is_wd);
wire next_watchdog_flag = wd_set || (o_watchdog_expired_flag && !wd_clr);
wire cd1_set = first_expire && first_is_cd;
wire next_first_flag = cd1_set || (o_first_countdown_flag && !i_first_countdown_flag_clear);
wire next_second_flag = second_expire ||
   (o_second_countdown_flag && !i_second_countdown_flag_clear);

always @(posedge i_clk) begin
   if (i_rst) begin
      o_watchdog_expired_flag <= 1'b0;
      o_first_countdown_flag <= 1'b0;
      o_second_countdown_flag <= 1'b0;
   end else begin
      o_watchdog_expired_flag <= next_watchdog_flag;
      o_first_countdown_flag <= next_first_flag;
      o_second_countdown_flag <= next_second_flag;
   end
end

// Pulse timers count oscillator ticks; a cleared flag cuts the pulse short
always @(posedge i_clk) begin
   if (i_rst) begin
      first_pulse <= 13'h0000;
      second_pulse <= 13'h0000;
   end else begin
      // A watchdog clear in watchdog mode also ends its pulse
      if (first_expire) begin
         first_pulse <= pulse_len(first_tick_select, first_n, 1'b0, 3'h0);
      end else if (wd_clr && first_is_wd) begin
         first_pulse <= 13'h0000;
      end else if (i_osc_en && first_pulse != 13'h0000) begin
         first_pulse <= first_pulse - 13'h0001;
      end
      if (second_expire) begin
         second_pulse <= pulse_len(second_tick_select, second_n, 1'b1, second_pulse_width);
      end else if (i_osc_en && second_pulse != 13'h0000) begin
         second_pulse <= second_pulse - 13'h0001;
      end
   end
end

// Pulse starts on the expiry edge itself, together with its flag
wire first_shape = !i_first_pulse_mode || first_expire ||
   (first_pulse != 13'h0000);
wire second_shape = !i_second_pulse_mode || second_expire ||
   (second_pulse != 13'h0000);
wire wd_irq = next_watchdog_flag && i_watchdog_irq_enable && first_shape;
wire cd1_irq = next_first_flag && i_first_countdown_irq_enable && first_shape;
wire cd2_irq = next_second_flag && i_second_countdown_irq_enable && second_shape;

// Pins are active low
always @(posedge i_clk) begin
   if (i_rst) begin
      o_irq_out_primary_n <= 1'b1;
      o_irq_out_secondary_n <= 1'b1;
   end else begin
      o_irq_out_primary_n <= !(wd_irq || cd1_irq || cd2_irq);
      o_irq_out_secondary_n <= !cd2_irq;
   end
end

endmodule

// >>> sim/rtcdt_timers_assertions.sv
// Port-level checker for the dual countdown timers
`timescale 1ns/1ps
module rtcdt_chk (
   input wire i_clk,
   input wire i_rst,
   input wire [1:0] i_first_function_select,
   input wire i_second_timer_on,
   input wire i_first_pulse_mode,
   input wire i_second_pulse_mode,
   input wire i_watchdog_irq_enable,
   input wire i_first_countdown_irq_enable,
   input wire i_second_countdown_irq_enable,
   input wire i_control2_read,
   input wire i_first_countdown_flag_clear,
   input wire i_second_countdown_flag_clear,
   input wire o_watchdog_expired_flag,
   input wire o_first_countdown_flag,
   input wire o_second_countdown_flag,
   input wire o_irq_out_primary_n,
   input wire o_irq_out_secondary_n
);
   wire fw = o_watchdog_expired_flag;
   wire f1 = o_first_countdown_flag;
   wire f2 = o_second_countdown_flag;
   wire p1 = o_irq_out_primary_n;
   wire p2 = o_irq_out_secondary_n;
   wire lv1 = f1 && i_first_countdown_irq_enable && !i_first_pulse_mode;
   wire lv2 = f2 && i_second_countdown_irq_enable && !i_second_pulse_mode;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   AST_F1_HOLD: assert property (f1 && !i_first_countdown_flag_clear |=> f1)
      else $error("first flag dropped without clear");
   AST_F2_HOLD: assert property (f2 && !i_second_countdown_flag_clear |=> f2)
      else $error("second flag dropped without clear");
   AST_WD_RDCLR: assert property (fw && i_control2_read |=> !fw)
      else $error("watchdog flag survived control read");
   AST_F1_LEVEL: assert property (lv1[*2] |-> !p1)
      else $error("primary pin not low for first flag");
   AST_F2_LEVEL: assert property (lv2[*2] |-> !p2 && !p1)
      else $error("pins not low for second flag");
   AST_QUIET: assert property ((!f1 && !f2 && !fw)[*2] |-> p1 && p2)
      else $error("interrupt pin low with no flag set");
   AST_WD_NOIRQ: assert property ((fw && !i_watchdog_irq_enable && !f1 && !f2)[*2] |-> p1)
      else $error("watchdog interrupt while disabled");
   AST_WD_MODE: assert property ((i_first_function_select != 2'h2)[*2] |-> !$rose(fw))
      else $error("watchdog flag set outside watchdog mode");
   AST_F1_OFF: assert property ((i_first_function_select == 2'h0)[*2] |-> !$rose(f1))
      else $error("first flag set while timer off");
   AST_F2_OFF: assert property ((!i_second_timer_on)[*2] |-> !$rose(f2))
      else $error("second flag set while timer off");
   cover property ($rose(f1));
   cover property ($rose(fw) && !p1);
   cover property ($rose(f2) && i_second_pulse_mode);
endmodule

// >>> sim/rtcdt_host.sv
// Host model issuing register writes and reads
`timescale 1ns/1ps
module rtcdt_host (
   input wire i_clk,
   input wire [7:0] i_reg_rdata,
   output reg [4:0] o_reg_addr,
   output reg [7:0] o_reg_wdata,
   output reg o_reg_we,
   output reg o_reg_re
);
   initial begin
      o_reg_addr = 5'h00;
      o_reg_wdata = 8'h00;
      o_reg_we = 1'b0;
      o_reg_re = 1'b0;
   end
   task wr(input [4:0] a, input [7:0] d);
      begin
         @(posedge i_clk);
         o_reg_addr <= a;
         o_reg_wdata <= d;
         o_reg_we <= 1'b1;
         @(posedge i_clk);
         o_reg_we <= 1'b0;
         // Released data must not look like the byte just sent
         o_reg_wdata <= ~d;
      end
   endtask
   task rd(input [4:0] a, output [7:0] d);
      begin
         @(posedge i_clk);
         o_reg_addr <= a;
         o_reg_re <= 1'b1;
         @(posedge i_clk);
         o_reg_re <= 1'b0;
         #1;
         d = i_reg_rdata;
      end
   endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench for the dual countdown timers
`timescale 1ns/1ps
module tb;
   reg i_clk = 1'b0;
   reg i_rst = 1'b1;
   reg osc = 1'b0;
   reg [1:0] oc = 2'h0;
   reg [1:0] fs = 2'h0;
   reg on2 = 1'b0, pm1 = 1'b0, pm2 = 1'b0, wie = 1'b0, ie1 = 1'b0, ie2 = 1'b0;
   reg c2rd = 1'b0, clr1 = 1'b0, clr2 = 1'b0;
   wire [4:0] ad;
   wire [7:0] wd, rdata;
   wire we, re, fw, f1, f2, p1, p2;
   integer fails = 0;
   integer num_checks = 0;
   integer n;
   reg [7:0] v;
   time t0;
   always #5 i_clk = ~i_clk;
   // Oscillator enable every 4 clocks keeps tick periods short
   always @(posedge i_clk) begin
      oc <= oc + 2'h1;
      osc <= (oc == 2'h3);
   end
   rtcdt_host rtcdt_host_inst (.i_clk(i_clk), .i_reg_rdata(rdata), .o_reg_addr(ad),
      .o_reg_wdata(wd), .o_reg_we(we), .o_reg_re(re));
   rtcdt_timers rtcdt_timers_inst (.i_clk(i_clk), .i_rst(i_rst), .i_osc_en(osc),
      .i_reg_addr(ad), .i_reg_wdata(wd), .i_reg_we(we), .i_reg_re(re), .o_reg_rdata(rdata),
      .i_first_function_select(fs), .i_second_timer_on(on2), .i_first_pulse_mode(pm1),
      .i_second_pulse_mode(pm2), .i_watchdog_irq_enable(wie),
      .i_first_countdown_irq_enable(ie1), .i_second_countdown_irq_enable(ie2),
      .i_control2_read(c2rd), .i_first_countdown_flag_clear(clr1),
      .i_second_countdown_flag_clear(clr2), .o_watchdog_expired_flag(fw),
      .o_first_countdown_flag(f1), .o_second_countdown_flag(f2),
      .o_irq_out_primary_n(p1), .o_irq_out_secondary_n(p2));
   task chk(input string nm, input [7:0] e, input [7:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            fails = fails + 1;
         end
      end
   endtask
   task wt(input integer s, input integer lim);
      begin
         n = 0;
         while (((s == 0) ? f1 : (s == 1) ? fw : f2) !== 1'b1 && n < lim) begin
            @(posedge i_clk);
            #1;
            n = n + 1;
         end
      end
   endtask
   task pulse(input integer s);
      begin
         @(posedge i_clk);
         clr1 <= (s == 0);
         c2rd <= (s == 1);
         clr2 <= (s == 2);
         @(posedge i_clk);
         clr1 <= 1'b0;
         c2rd <= 1'b0;
         clr2 <= 1'b0;
         #1;
      end
   endtask
   task t_regs;
      begin
         rtcdt_host_inst.rd(5'h10, v);
         chk("sel1", 8'h07, v);
         rtcdt_host_inst.rd(5'h12, v);
         chk("sel2", 8'h07, v);
         rtcdt_host_inst.wr(5'h12, 8'hff);
         rtcdt_host_inst.rd(5'h12, v);
         chk("sel2w", 8'h77, v);
         rtcdt_host_inst.wr(5'h10, 8'hf9);
         rtcdt_host_inst.rd(5'h10, v);
         chk("sel1w", 8'h01, v);
         rtcdt_host_inst.wr(5'h05, 8'h5a);
         rtcdt_host_inst.rd(5'h05, v);
         chk("unmapped", 8'h00, v);
      end
   endtask
   task t_cd1;
      begin
         @(posedge i_clk);
         fs <= 2'h1;
         ie1 <= 1'b1;
         rtcdt_host_inst.wr(5'h10, 8'h00);
         rtcdt_host_inst.wr(5'h11, 8'h03);
         wt(0, 300);
         t0 = $time;
         chk("f1", 8'h01, 8'(f1));
         chk("p1lvl", 8'h00, 8'(p1));
         rtcdt_host_inst.rd(5'h11, v);
         chk("reload", 8'h03, v);
         repeat (32) @(posedge i_clk);
         rtcdt_host_inst.rd(5'h11, v);
         chk("live", 8'h02, v);
         chk("f1held", 8'h01, 8'(f1));
         pulse(0);
         chk("p1clr", 8'h01, 8'(p1));
         wt(0, 300);
         chk("period", 8'd96, 8'(($time - t0) / 10));
         @(posedge i_clk);
         pm1 <= 1'b1;
         pulse(0);
         wt(0, 300);
         repeat (28) @(posedge i_clk);
         chk("p1pls", 8'h00, 8'(p1));
         repeat (6) @(posedge i_clk);
         chk("p1end", 8'h01, 8'(p1));
         rtcdt_host_inst.wr(5'h11, 8'h00);
         pulse(0);
         repeat (200) @(posedge i_clk);
         chk("halt", 8'h00, 8'(f1));
      end
   endtask
   task t_wd;
      begin
         @(posedge i_clk);
         fs <= 2'h2;
         pm1 <= 1'b0;
         rtcdt_host_inst.wr(5'h11, 8'h02);
         wt(1, 300);
         chk("wdf", 8'h01, 8'(fw));
         chk("wdoff", 8'h01, 8'(p1));
         rtcdt_host_inst.rd(5'h11, v);
         chk("noreload", 8'h00, v);
         pulse(1);
         chk("rdclr", 8'h00, 8'(fw));
         @(posedge i_clk);
         wie <= 1'b1;
         rtcdt_host_inst.wr(5'h11, 8'h02);
         wt(1, 300);
         chk("wdirq", 8'h00, 8'(p1));
         @(posedge i_clk);
         pm1 <= 1'b1;
         rtcdt_host_inst.wr(5'h11, 8'h05);
         #1;
         chk("wrclr", 8'h00, 8'(fw));
         chk("wrirq", 8'h01, 8'(p1));
         wt(1, 400);
         chk("wdpls", 8'h00, 8'(p1));
         repeat (34) @(posedge i_clk);
         chk("wdplsend", 8'h01, 8'(p1));
         rtcdt_host_inst.wr(5'h11, 8'h00);
         #1;
         chk("zeroclr", 8'h00, 8'(fw));
         rtcdt_host_inst.wr(5'h11, 8'h05);
         rtcdt_host_inst.wr(5'h11, 8'h00);
         repeat (200) @(posedge i_clk);
         chk("stopped", 8'h00, 8'(fw));
         fs <= 2'h0;
      end
   endtask
   task t_b;
      begin
         rtcdt_host_inst.wr(5'h12, 8'h00);
         rtcdt_host_inst.wr(5'h13, 8'h02);
         on2 <= 1'b1;
         ie2 <= 1'b1;
         wt(2, 300);
         chk("p2", 8'h00, 8'(p2));
         chk("p1b", 8'h00, 8'(p1));
         repeat (70) @(posedge i_clk);
         chk("f2held", 8'h01, 8'(f2));
         pm2 <= 1'b1;
         pulse(2);
         wt(2, 300);
         chk("p2pls", 8'h00, 8'(p2));
         repeat (34) @(posedge i_clk);
         chk("p2end", 8'h01, 8'(p2));
         on2 <= 1'b0;
         pulse(2);
         repeat (200) @(posedge i_clk);
         chk("b_off", 8'h00, 8'(f2));
      end
   endtask
   task t_slow;
      begin
         fs <= 2'h1;
         rtcdt_host_inst.wr(5'h10, 8'h01);
         rtcdt_host_inst.wr(5'h11, 8'h01);
         wt(0, 5000);
         chk("first64", 8'h01, 8'(n >= 2040 && n <= 4110));
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d fails %0d", num_checks, fails);
         if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      t_regs;
      t_cd1;
      t_wd;
      t_b;
      t_slow;
      end_of_test;
   end
   initial begin
      #500000;
      fails = fails + 1;
      end_of_test;
   end
endmodule
bind rtcdt_timers rtcdt_chk rtcdt_chk_inst (.*);
